//--- shared/bus_intr_pkg.sv
// constants and types shared by the interrupt posting block and its pending counters
package bus_intr_pkg;
  localparam int NUM_LEVELS  = 4;   // vectored interrupt levels
  localparam int LEVEL_W     = 2;   // level index width
  localparam int QUEUE_DEPTH = 4;   // most interrupts pending per level
  localparam int QIDX_W      = 2;   // queue slot index width
  localparam int QCNT_W      = 3;   // queue occupancy width (0..4)
  localparam int NUM_TARGETS = 4;   // most processors that can be targets
  localparam int NODE_W      = 4;   // node identifier width
  localparam int CNT_W       = 7;   // per-level pending counter width
  localparam int NUM_CH      = 8;   // io channels feeding the port module
  localparam int CH_W        = 3;   // channel index width
  localparam int VEC_W       = 16;  // interrupt vector width
  localparam int DATA_W      = 32;  // bus read data width

  localparam logic [QCNT_W-1:0] QCNT_RST  = 3'h0;       // queue empty after reset
  localparam logic [QCNT_W-1:0] QCNT_FULL = 3'h4;       // queue full mark
  localparam logic [CNT_W-1:0]  CNT_RST   = 7'h00;      // pending counter after reset
  localparam logic [CNT_W-1:0]  CNT_MAX   = 7'h7f;      // pending counter ceiling
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000; // passive release answer

  // posting engine states, one-hot
  typedef enum logic [1:0] {
    POST_IDLE = 2'b01,  // waiting for an unposted vector
    POST_BUSY = 2'b10   // write to the posting register on the bus
  } post_state_type;
endpackage

//--- hw/pending_counter.sv
// per-level pending interrupt counters of a processor node
`timescale 1ns/10ps
`default_nettype none
module pending_counter
  import bus_intr_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // node identity
  input  wire logic [NODE_W-1:0]      myNodeId,
  // observed posting register writes
  input  wire logic                   obsWrValid,
  input  wire logic [LEVEL_W-1:0]     obsWrLevel,
  input  wire logic [NUM_TARGETS-1:0] obsWrMask,
  // observed vector register reads, any commander
  input  wire logic                   obsRdValid,
  input  wire logic [LEVEL_W-1:0]     obsRdLevel,
  // interrupt lines
  output logic      [NUM_LEVELS-1:0]  intLine
);
  logic [CNT_W-1:0]      cnt_ff [NUM_LEVELS];     // pending count per level
  logic [CNT_W-1:0]      nxt_cnt [NUM_LEVELS];
  logic [NUM_LEVELS-1:0] intLine_ff;              // registered non-zero flags
  logic [NUM_LEVELS-1:0] nxt_intLine;
  logic                  eligible;                // node may be a target
  logic                  hit;                     // write names this node

  // only the low node ids can be targets, each maps to one mask bit
  assign eligible = (myNodeId < NODE_W'(NUM_TARGETS));
  assign hit      = eligible && obsWrMask[myNodeId[1:0]];

  // next counts: increment on a write naming us, decrement on any vector read
  always_comb begin
    for (int l = 0; l < NUM_LEVELS; l++) begin
      nxt_cnt[l] = cnt_ff[l];
      // both in one cycle cancel out below CNT_MAX; at CNT_MAX only the read's decrement applies
      if (obsWrValid && hit && obsWrLevel == LEVEL_W'(l) && cnt_ff[l] != CNT_MAX) begin
        nxt_cnt[l] = cnt_ff[l] + 7'h01;
      end
      if (obsRdValid && obsRdLevel == LEVEL_W'(l) && nxt_cnt[l] != CNT_RST) begin
        nxt_cnt[l] = nxt_cnt[l] - 7'h01;
      end
      nxt_intLine[l] = (nxt_cnt[l] != CNT_RST);
    end
  end

  // register counters; line flag tracks the count in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int l = 0; l < NUM_LEVELS; l++) begin
        cnt_ff[l] <= CNT_RST;
      end
      intLine_ff <= '0;
    end else begin
      cnt_ff     <= nxt_cnt;
      intLine_ff <= nxt_intLine;
    end
  end

  assign intLine = intLine_ff;
endmodule
`default_nettype wire

//--- hw/bus_interrupt_posting.sv
// vectored interrupt posting: port module queues and posting engine plus processor counters
`timescale 1ns/10ps
`default_nettype none
module bus_interrupt_posting
  import bus_intr_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // adapter interrupt requests
  input  wire logic                   postReq,
  input  wire logic [LEVEL_W-1:0]     postLevel,
  input  wire logic [CH_W-1:0]        postChannel,
  input  wire logic [VEC_W-1:0]       postVector,
  output logic                        postAck,
  output logic                        postReject,
  // target selection
  input  wire logic [NUM_TARGETS-1:0] processor_target_mask,
  // outgoing write to the posting register
  output logic                        postWrValid,
  output logic      [LEVEL_W-1:0]     postWrLevel,
  output logic      [NUM_TARGETS-1:0] postWrMask,
  input  wire logic [NUM_TARGETS-1:0] target_confirm,
  // vector register reads seen on the bus
  input  wire logic                   vecRdValid,
  input  wire logic [LEVEL_W-1:0]     vecRdLevel,
  output logic                        vecRdDataValid,
  output logic      [DATA_W-1:0]      vecRdData,
  // processor side: observed posting writes and node identity
  input  wire logic                   obsWrValid,
  input  wire logic [LEVEL_W-1:0]     obsWrLevel,
  input  wire logic [NUM_TARGETS-1:0] obsWrMask,
  input  wire logic [NODE_W-1:0]      myNodeId,
  output logic      [NUM_LEVELS-1:0]  intLine
);
  // lowest level holding an unposted vector, msb flags found
  function automatic logic [LEVEL_W:0] pick_level(input logic [QCNT_W-1:0] un [NUM_LEVELS]);
    logic [LEVEL_W:0] r;
    r = '0;
    for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
      if (un[l] != QCNT_RST) begin
        r = {1'b1, LEVEL_W'(l)};
      end
    end
    return r;
  endfunction

  // queue storage, one ring per level
  logic [VEC_W-1:0]      vecMem_ff [NUM_LEVELS][QUEUE_DEPTH];  // queued vectors
  logic [CH_W-1:0]       chMem_ff  [NUM_LEVELS][QUEUE_DEPTH];  // owning channel per slot
  logic [VEC_W-1:0]      nxt_vecMem [NUM_LEVELS][QUEUE_DEPTH];
  logic [CH_W-1:0]       nxt_chMem  [NUM_LEVELS][QUEUE_DEPTH];
  logic [QIDX_W-1:0]     head_ff [NUM_LEVELS];                 // oldest slot
  logic [QIDX_W-1:0]     nxt_head [NUM_LEVELS];
  logic [QCNT_W-1:0]     qCnt_ff [NUM_LEVELS];                 // vectors not yet serviced
  logic [QCNT_W-1:0]     nxt_qCnt [NUM_LEVELS];
  logic [QCNT_W-1:0]     unposted_ff [NUM_LEVELS];             // queued but not yet posted
  logic [QCNT_W-1:0]     nxt_unposted [NUM_LEVELS];
  logic [NUM_CH-1:0]     chBusy_ff [NUM_LEVELS];               // channel has one pending
  logic [NUM_CH-1:0]     nxt_chBusy [NUM_LEVELS];
  // answer registers
  logic                  postAck_ff, nxt_postAck;
  logic                  postReject_ff, nxt_postReject;
  logic                  rdValid_ff, nxt_rdValid;
  logic [DATA_W-1:0]     rdData_ff, nxt_rdData;
  // posting engine
  post_state_type        state_ff, nxt_state;
  logic [LEVEL_W-1:0]    wrLevel_ff, nxt_wrLevel;
  logic [NUM_TARGETS-1:0] wrMask_ff, nxt_wrMask;
  logic                  wrValid_ff, nxt_wrValid;
  // decoded strobes
  logic                  accept;       // request enters a queue
  logic                  pop;          // vector read finds something pending
  logic                  postDone;     // posting write confirmed
  logic [LEVEL_W:0]      pick;         // engine choice
  logic [QIDX_W-1:0]     tail;         // free slot at request level
  logic [QIDX_W-1:0]     rdSlot;       // slot being serviced

  // a full level or a busy channel refuses the request outright
  assign accept = postReq && (qCnt_ff[postLevel] != QCNT_FULL)
                  && !chBusy_ff[postLevel][postChannel];
  assign pop    = vecRdValid && (qCnt_ff[vecRdLevel] != QCNT_RST);
  assign tail   = head_ff[postLevel] + qCnt_ff[postLevel][QIDX_W-1:0];
  assign rdSlot = head_ff[vecRdLevel];
  // any single responder is enough; several may answer together
  assign postDone = (state_ff == POST_BUSY) && (target_confirm != '0);
  assign pick   = pick_level(unposted_ff);

  // queue bookkeeping next values
  always_comb begin
    nxt_vecMem   = vecMem_ff;
    nxt_chMem    = chMem_ff;
    nxt_head     = head_ff;
    nxt_chBusy   = chBusy_ff;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      nxt_qCnt[l]     = qCnt_ff[l];
      nxt_unposted[l] = unposted_ff[l];
      if (accept && postLevel == LEVEL_W'(l)) begin
        nxt_qCnt[l]     = nxt_qCnt[l] + 3'h1;
        nxt_unposted[l] = nxt_unposted[l] + 3'h1;
      end
      if (pop && vecRdLevel == LEVEL_W'(l)) begin
        nxt_qCnt[l] = nxt_qCnt[l] - 3'h1;
        nxt_head[l] = head_ff[l] + 2'h1;
      end
      if (postDone && wrLevel_ff == LEVEL_W'(l)) begin
        nxt_unposted[l] = nxt_unposted[l] - 3'h1;
      end
    end
    // read frees the channel before a same-cycle request claims it
    if (pop) begin
      nxt_chBusy[vecRdLevel][chMem_ff[vecRdLevel][rdSlot]] = 1'b0;
    end
    if (accept) begin
      nxt_vecMem[postLevel][tail]         = postVector;
      nxt_chMem[postLevel][tail]          = postChannel;
      nxt_chBusy[postLevel][postChannel]  = 1'b1;
    end
  end

  // register queue state
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int l = 0; l < NUM_LEVELS; l++) begin
        head_ff[l]     <= '0;
        qCnt_ff[l]     <= QCNT_RST;
        unposted_ff[l] <= QCNT_RST;
        chBusy_ff[l]   <= '0;
        for (int s = 0; s < QUEUE_DEPTH; s++) begin
          vecMem_ff[l][s] <= '0;
          chMem_ff[l][s]  <= '0;
        end
      end
    end else begin
      vecMem_ff   <= nxt_vecMem;
      chMem_ff    <= nxt_chMem;
      head_ff     <= nxt_head;
      qCnt_ff     <= nxt_qCnt;
      unposted_ff <= nxt_unposted;
      chBusy_ff   <= nxt_chBusy;
    end
  end

  // answers to adapters and to vector reads
  always_comb begin
    nxt_postAck    = accept;
    nxt_postReject = postReq && !accept;
    nxt_rdValid    = vecRdValid;
    nxt_rdData     = DATA_ZERO;
    if (pop) begin
      // oldest vector goes to whoever reads first; later readers see the next or zero
      nxt_rdData = DATA_W'(vecMem_ff[vecRdLevel][rdSlot]);
    end
  end

  // register answers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      postAck_ff    <= 1'b0;
      postReject_ff <= 1'b0;
      rdValid_ff    <= 1'b0;
      rdData_ff     <= DATA_ZERO;
    end else begin
      postAck_ff    <= nxt_postAck;
      postReject_ff <= nxt_postReject;
      rdValid_ff    <= nxt_rdValid;
      rdData_ff     <= nxt_rdData;
    end
  end

  // posting engine: one write at a time, lowest level first
  always_comb begin
    nxt_state   = state_ff;
    nxt_wrLevel = wrLevel_ff;
    nxt_wrMask  = wrMask_ff;
    nxt_wrValid = wrValid_ff;
    case (state_ff)
      POST_IDLE: begin
        // only vectors already in a queue are posted
        if (pick[LEVEL_W]) begin
          nxt_state   = POST_BUSY;
          nxt_wrLevel = pick[LEVEL_W-1:0];
          nxt_wrMask  = processor_target_mask;
          nxt_wrValid = 1'b1;
        end
      end
      POST_BUSY: begin
        // held until confirmed; no timeout, an unanswered post stalls the engine
        if (postDone) begin
          nxt_state   = POST_IDLE;
          nxt_wrValid = 1'b0;
        end
      end
      default: begin
        nxt_state   = POST_IDLE;
        nxt_wrValid = 1'b0;
      end
    endcase
  end

  // register engine
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff   <= POST_IDLE;
      wrLevel_ff <= '0;
      wrMask_ff  <= '0;
      wrValid_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      wrLevel_ff <= nxt_wrLevel;
      wrMask_ff  <= nxt_wrMask;
      wrValid_ff <= nxt_wrValid;
    end
  end

  // processor side counters and interrupt lines
  pending_counter u_pending (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .myNodeId   (myNodeId),
    .obsWrValid (obsWrValid),
    .obsWrLevel (obsWrLevel),
    .obsWrMask  (obsWrMask),
    .obsRdValid (vecRdValid),
    .obsRdLevel (vecRdLevel),
    .intLine    (intLine)
  );

  assign postAck        = postAck_ff;
  assign postReject     = postReject_ff;
  assign postWrValid    = wrValid_ff;
  assign postWrLevel    = wrLevel_ff;
  assign postWrMask     = wrMask_ff;
  assign vecRdDataValid = rdValid_ff;
  assign vecRdData      = rdData_ff;
endmodule
`default_nettype wire

//--- test/bus_intr_checker_asserts.sv
// port-level assertions for the interrupt posting block
`timescale 1ns/10ps
`default_nettype none
module bus_intr_checker
  import bus_intr_pkg::*;
(
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   nrst,
  // adapter side
  input wire logic                   postReq,
  input wire logic                   postAck,
  input wire logic                   postReject,
  // posting write
  input wire logic                   postWrValid,
  input wire logic [LEVEL_W-1:0]     postWrLevel,
  input wire logic [NUM_TARGETS-1:0] postWrMask,
  input wire logic [NUM_TARGETS-1:0] target_confirm,
  // vector reads
  input wire logic                   vecRdValid,
  input wire logic                   vecRdDataValid,
  input wire logic [DATA_W-1:0]      vecRdData,
  // processor counters
  input wire logic                   obsWrValid,
  input wire logic [LEVEL_W-1:0]     obsWrLevel,
  input wire logic [NUM_TARGETS-1:0] obsWrMask,
  input wire logic [NODE_W-1:0]      myNodeId,
  input wire logic [NUM_LEVELS-1:0]  intLine
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic elig;  // observed write names this node
  assign elig = obsWrValid && myNodeId[3:2] == 2'h0 && obsWrMask[myNodeId[1:0]];

  ack_has_req_a: assert property (postAck |-> $past(postReq) && !postReject)
    else $error("ack without a request");
  rej_has_req_a: assert property (postReject |-> $past(postReq))
    else $error("reject without a request");
  wr_held_a: assert property (postWrValid && target_confirm == 4'h0 |=>
    postWrValid && $stable(postWrLevel) && $stable(postWrMask)) else $error("post write changed before confirm");
  wr_ends_a: assert property (postWrValid && target_confirm != 4'h0 |=> !postWrValid)
    else $error("post write kept after confirm");
  rd_answer_a: assert property (vecRdValid |=> vecRdDataValid)
    else $error("vector read not answered");
  rd_cause_a: assert property (vecRdDataValid |-> $past(vecRdValid) && vecRdData[31:16] == 16'h0000)
    else $error("bad vector read answer");
  line_rise_a: assert property (elig && !vecRdValid |=> intLine[$past(obsWrLevel)])
    else $error("interrupt line not raised by post");
  line_floor_a: assert property (vecRdValid && !obsWrValid && intLine == 4'h0 |=> intLine == 4'h0)
    else $error("counter went below zero");
  no_target_a: assert property (!elig && !vecRdValid && intLine == 4'h0 |=> intLine == 4'h0)
    else $error("line raised without eligible post");
  rst_clear_a: assert property (disable iff (1'b0) !nrst |=> intLine == 4'h0 && !postWrValid)
    else $error("state not cleared by reset");

  // main scenarios reached
  cover property (postReject);
  cover property (postWrValid && target_confirm[0] && target_confirm[1]);
  cover property (vecRdDataValid && vecRdData == 32'h0000_0000);
  cover property (intLine == 4'hf);
endmodule

bind bus_interrupt_posting bus_intr_checker chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .postReq(postReq), .postAck(postAck), .postReject(postReject),
  .postWrValid(postWrValid), .postWrLevel(postWrLevel), .postWrMask(postWrMask),
  .target_confirm(target_confirm), .vecRdValid(vecRdValid), .vecRdDataValid(vecRdDataValid),
  .vecRdData(vecRdData), .obsWrValid(obsWrValid), .obsWrLevel(obsWrLevel), .obsWrMask(obsWrMask),
  .myNodeId(myNodeId), .intLine(intLine));
`default_nettype wire

//--- test/post_responder.sv
// model of the bus nodes that confirm and observe posting writes
`timescale 1ns/10ps
`default_nettype none
module post_responder
  import bus_intr_pkg::*;
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   nrst,
  // posting write from the port module
  input  wire logic                   postWrValid,
  input  wire logic [LEVEL_W-1:0]     postWrLevel,
  input  wire logic [NUM_TARGETS-1:0] postWrMask,
  // confirm delay in cycles, 0 is prompt
  input  wire logic [2:0]             slowDly,
  // confirm and the write as every node sees it
  output logic      [NUM_TARGETS-1:0] target_confirm,
  output logic                        obsWrValid,
  output logic      [LEVEL_W-1:0]     obsWrLevel,
  output logic      [NUM_TARGETS-1:0] obsWrMask
);
  logic [2:0] dly_ff, nxt_dly;    // cycles waited on this write
  logic       conf_ff, nxt_conf;  // confirm cycle

  // count the wait, confirm for one cycle only
  always_comb begin
    nxt_dly  = dly_ff;
    nxt_conf = 1'b0;
    if (postWrValid && !conf_ff) begin
      if (dly_ff == slowDly) begin
        nxt_conf = 1'b1;
        nxt_dly  = 3'h0;
      end else begin
        nxt_dly = dly_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dly_ff  <= 3'h0;
      conf_ff <= 1'b0;
    end else begin
      dly_ff  <= nxt_dly;
      conf_ff <= nxt_conf;
    end
  end

  // every addressed node confirms at once
  assign target_confirm = conf_ff ? postWrMask : 4'h0;
  // only vectored posting writes are seen here; non-vectored ones go to broadcast space
  assign obsWrValid     = conf_ff;
  assign obsWrLevel     = postWrLevel;
  assign obsWrMask      = postWrMask;
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the interrupt posting block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import bus_intr_pkg::*;
;
  logic                   ref_clk, nrst, postReq, postAck, postReject, postWrValid;
  logic                   vecRdValid, vecRdDataValid, obsWrValid;
  logic [LEVEL_W-1:0]     postLevel, postWrLevel, vecRdLevel, obsWrLevel;
  logic [CH_W-1:0]        postChannel;
  logic [VEC_W-1:0]       postVector;
  logic [NUM_TARGETS-1:0] mask, postWrMask, target_confirm, obsWrMask;
  logic [NODE_W-1:0]      nodeId;
  logic [NUM_LEVELS-1:0]  intLine;
  logic [DATA_W-1:0]      vecRdData;
  logic [2:0]             slowDly;
  logic [31:0]            rnd = 32'hbecb;   // fixed seed
  int                     n_mismatch = 0, checks = 0, nAcc = 0, nWr = 0;
  int                     cnt [NUM_LEVELS]; // expected pending counts
  int                     nUnp [NUM_LEVELS]; // accepted but not yet seen on the bus, per level
  logic [18:0]            q [NUM_LEVELS][$]; // expected queues, channel and vector
  bit                     pend [NUM_LEVELS][NUM_CH];

  always #20 ref_clk = ~ref_clk;

  bus_interrupt_posting dut_u (.ref_clk(ref_clk), .nrst(nrst), .postReq(postReq), .postLevel(postLevel),
    .postChannel(postChannel), .postVector(postVector), .postAck(postAck), .postReject(postReject),
    .processor_target_mask(mask), .postWrValid(postWrValid), .postWrLevel(postWrLevel),
    .postWrMask(postWrMask), .target_confirm(target_confirm), .vecRdValid(vecRdValid),
    .vecRdLevel(vecRdLevel), .vecRdDataValid(vecRdDataValid), .vecRdData(vecRdData),
    .obsWrValid(obsWrValid), .obsWrLevel(obsWrLevel), .obsWrMask(obsWrMask), .myNodeId(nodeId),
    .intLine(intLine));
  post_responder resp_u (.ref_clk(ref_clk), .nrst(nrst), .postWrValid(postWrValid),
    .postWrLevel(postWrLevel), .postWrMask(postWrMask), .slowDly(slowDly),
    .target_confirm(target_confirm), .obsWrValid(obsWrValid), .obsWrLevel(obsWrLevel),
    .obsWrMask(obsWrMask));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // a posting write reaches this node only for ids below the target count with their mask bit set
  function automatic bit names_node(input logic [NUM_TARGETS-1:0] m, input logic [NODE_W-1:0] id);
    return (id < NODE_W'(NUM_TARGETS)) && m[id[1:0]];
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one adapter request; refused when the level is full or the channel busy
  task automatic post(input logic [1:0] lv, input logic [2:0] ch, input logic [15:0] vec);
    logic ok;
    ok = q[lv].size() < QUEUE_DEPTH && !pend[lv][ch];
    @(posedge ref_clk);
    postReq <= 1'b1; postLevel <= lv; postChannel <= ch; postVector <= vec;
    @(posedge ref_clk);
    postReq <= 1'b0;
    #1 cmp({postAck, postReject}, {ok, !ok});
    if (ok) begin
      q[lv].push_back({ch, vec});
      pend[lv][ch] = 1'b1;
      nAcc++;
      nUnp[lv]++;
      if (names_node(mask, nodeId)) cnt[lv]++;
    end
  endtask

  // one vector read: oldest vector of the level, or zero
  task automatic rd(input logic [1:0] lv);
    logic [31:0] exp;
    exp = 32'h0;
    if (q[lv].size() > 0) begin
      exp = {16'h0, q[lv][0][15:0]};
      pend[lv][q[lv][0][18:16]] = 1'b0;
      void'(q[lv].pop_front());
    end
    if (cnt[lv] > 0) cnt[lv]--;
    @(posedge ref_clk);
    vecRdValid <= 1'b1; vecRdLevel <= lv;
    @(posedge ref_clk);
    vecRdValid <= 1'b0;
    #1 cmp(vecRdDataValid, 32'h1);
    cmp(vecRdData, exp);
  endtask

  // wait for the posting engine to go quiet, then compare writes and lines
  task automatic settle_chk;
    int idle;
    idle = 0;
    for (int i = 0; i < 400 && idle < 4; i++) begin
      @(posedge ref_clk);
      #1 idle = postWrValid ? 0 : idle + 1;
    end
    cmp(nWr, nAcc);
    for (int lv = 0; lv < NUM_LEVELS; lv++) cmp(intLine[lv], cnt[lv] != 0);
  endtask

  // off-edge monitor of the writes on the bus
  always @(negedge ref_clk) begin
    if (obsWrValid) begin
      nWr++;
      // a write may only carry a level that holds an accepted, unposted vector
      cmp(nUnp[postWrLevel] != 0, 32'h1);
      if (nUnp[postWrLevel] != 0) nUnp[postWrLevel]--;
    end
    if (postWrValid) cmp(postWrMask, mask);
  end

  task automatic finish_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    ref_clk = 1'b0; nrst = 1'b0; postReq = 1'b0; postLevel = 2'h0; postChannel = 3'h0;
    postVector = 16'h0; vecRdValid = 1'b0; vecRdLevel = 2'h0;
    mask = 4'h1; nodeId = 4'h0; slowDly = 3'h0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    settle_chk();
    for (int lv = 0; lv < NUM_LEVELS; lv++) post(lv[1:0], 3'h7, 16'hbe00 + 16'(lv));
    for (int c = 0; c < 5; c++) post(2'h2, c[2:0], 16'h0c00 + 16'(c));
    post(2'h1, 3'h7, 16'h0bad);
    settle_chk();
    repeat (6) rd(2'h2);
    for (int lv = 0; lv < NUM_LEVELS; lv++) rd(lv[1:0]);
    settle_chk();
    for (int b = 0; b < 24; b++) begin
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      mask <= (rnd[3:0] == 4'h0) ? 4'h3 : rnd[3:0];
      nodeId <= {1'b0, rnd[6:4]};
      slowDly <= rnd[9:7];
      repeat (6) begin
        rnd = lfsr(rnd);
        post(rnd[1:0], rnd[4:2], rnd[20:5]);
      end
      settle_chk();
      repeat (8) begin
        rnd = lfsr(rnd);
        rd(rnd[1:0]);
      end
      settle_chk();
    end
    finish_test();
  end
endmodule
`default_nettype wire
